// ===== dpsc_pkg.sv
// Behaviour
// - finish bit write starts user row flash programming
// - finish before data ready proceeds without data
// - finish bit writable only after row key
// - clock request keeps system clock in sleep
// - writing zero withdraws the clock request
// - port disable clears the clock request
// - programming mode entry sets clock request
// - reset-active bit shows system domain reset
// - reading system status clears reset-active bit
// - reset from reset request register also shown
// - in-sleep bit shows idle or deeper sleep
// - memory programming ready bit shows permission
// - user row ready bit shows permission
// - lock bit shows lock state, cleared after erase
// - one-hot checksum status: 0, 1, 2, 4
// - 0x59 asserts system reset, 0x00 releases
package dpsc_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] SYS_CTRL_ADDR   = 8'h0A;
	localparam logic [7:0] SYS_STATUS_ADDR = 8'h0B;
	localparam logic [7:0] CRC_STATUS_ADDR = 8'h0C;
	localparam logic [7:0] RESET_REQ_ADDR  = 8'h08;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int CTRL_CLOCK_BIT   = 0;
	localparam int CTRL_FINISH_BIT  = 1;
	localparam int STAT_LOCK_BIT    = 0;
	localparam int STAT_UROWRDY_BIT = 2;
	localparam int STAT_MEMRDY_BIT  = 3;
	localparam int STAT_SLEEP_BIT   = 4;
	localparam int STAT_RSTACT_BIT  = 5;
	localparam logic [7:0] SYS_CTRL_RESET   = 8'h00;
	localparam logic [7:0] SYS_STATUS_RESET = 8'h01;
	localparam logic [7:0] CRC_STATUS_RESET = 8'h00;

	// ****************************************
	// reset request signatures
	// ****************************************
	localparam logic [7:0] RESET_SIG_RUN   = 8'h00;
	localparam logic [7:0] RESET_SIG_RESET = 8'h59;

	// ****************************************
	// checksum status codes
	// ****************************************
	typedef enum logic [2:0] {
		DPSC_CRC_OFF  = 3'b000,
		DPSC_CRC_BUSY = 3'b001,
		DPSC_CRC_OK   = 3'b010,
		DPSC_CRC_FAIL = 3'b100
	} dpsc_crc_t;

	// ****************************************
	// user row session states
	// ****************************************
	typedef enum logic [1:0] {
		DPSC_ROW_IDLE  = 2'b00,
		DPSC_ROW_OPEN  = 2'b01,
		DPSC_ROW_WRITE = 2'b10
	} dpsc_row_t;
endpackage : dpsc_pkg

// ===== dpsc_reg_if.sv
// ****************************************
// register access carrier
// ****************************************
interface dpsc_reg_if;
	logic       wrEn;
	logic       rdEn;
	logic [7:0] addr;
	logic [7:0] wrData;
	modport master (output wrEn, rdEn, addr, wrData);
	modport slave  (input wrEn, rdEn, addr, wrData);
endinterface : dpsc_reg_if

// ===== dpsc_decode.sv
// ****************************************
// address decode of the register strobes
// ****************************************
module dpsc_decode
(
	// register access
	dpsc_reg_if.slave regs,
	// decoded strobes
	output logic      wrCtrl,
	output logic      wrReset,
	output logic      rdStatus
);
	import dpsc_pkg::*;

	// strobes for the addressed registers
	assign wrCtrl   = regs.wrEn && (regs.addr == SYS_CTRL_ADDR);
	assign wrReset  = regs.wrEn && (regs.addr == RESET_REQ_ADDR);
	assign rdStatus = regs.rdEn && (regs.addr == SYS_STATUS_ADDR);
endmodule : dpsc_decode

// ===== dpsc_top.sv
// ****************************************
// system control and status of the access layer
// ****************************************
module dpsc_top
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// register access from the link
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	output logic      [7:0] regRdData,
	// port state
	input  wire logic       portEnable,
	input  wire logic       progEntry,
	input  wire logic       userRowKeyOk,
	input  wire logic       userRowDataInRam,
	// system state
	input  wire logic       sysInReset,
	input  wire logic       sysSleeping,
	input  wire logic       memProgAllowed,
	input  wire logic       userRowAllowed,
	input  wire logic       deviceLocked,
	input  wire logic       crcEnabled,
	input  wire logic       crcDone,
	input  wire logic       crcPass,
	// system requests
	output logic            sysClockRequest,
	output logic            sysResetRequest,
	output logic            userRowProgStart,
	output logic            userRowUseData
);
	import dpsc_pkg::*;

	dpsc_reg_if regs();
	logic      wrCtrl;
	logic      wrReset;
	logic      rdStatus;
	logic      clock_request_reg, clock_request_next;
	logic      rstReq_reg, rstReq_next;
	logic      rstAct_reg, rstAct_next;
	logic      start_reg;
	logic      useData_reg;
	dpsc_row_t row_reg, row_next;
	logic [7:0] rdData_reg, rdData_next;
	logic [7:0] statusWord;
	dpsc_crc_t crcCode;
	logic      finishHit;

	// ****************************************
	// access decode
	// ****************************************
	assign regs.wrEn   = regWrEn;
	assign regs.rdEn   = regRdEn;
	assign regs.addr   = regAddr;
	assign regs.wrData = regWrData;

	dpsc_decode u_decode (
		.regs     (regs),
		.wrCtrl   (wrCtrl),
		.wrReset  (wrReset),
		.rdStatus (rdStatus)
	);

	// finish accepted only with the row key
	assign finishHit = wrCtrl && regWrData[CTRL_FINISH_BIT] && userRowKeyOk;

	// clock request: disable wins, entry sets, write steers
	assign clock_request_next = !portEnable ? 1'b0 :
		progEntry ? 1'b1 :
		wrCtrl ? regWrData[CTRL_CLOCK_BIT] :
		clock_request_reg;

	// reset request register, other values hold
	assign rstReq_next = (wrReset && regWrData == RESET_SIG_RESET) ? 1'b1 :
		(wrReset && regWrData == RESET_SIG_RUN) ? 1'b0 : rstReq_reg;

	// reset-active flag: set wins over read clear
	assign rstAct_next = (sysInReset || rstReq_reg) ? 1'b1 :
		rdStatus ? 1'b0 : rstAct_reg;

	// user row session tracking
	always_comb begin
		row_next = row_reg;
		case (row_reg)
			DPSC_ROW_IDLE: begin
				if (userRowAllowed)
					row_next = DPSC_ROW_OPEN;
			end
			DPSC_ROW_OPEN: begin
				if (finishHit)
					row_next = DPSC_ROW_WRITE;
			end
			DPSC_ROW_WRITE: begin
				row_next = DPSC_ROW_IDLE;
			end
			default: row_next = DPSC_ROW_IDLE;
		endcase
	end

	// checksum status one-hot code
	assign crcCode = !crcEnabled ? DPSC_CRC_OFF :
		!crcDone ? DPSC_CRC_BUSY :
		crcPass ? DPSC_CRC_OK : DPSC_CRC_FAIL;

	// status word, unused bits zero
	always_comb begin
		statusWord = 8'h00;
		statusWord[STAT_RSTACT_BIT]  = rstAct_reg;
		statusWord[STAT_SLEEP_BIT]   = sysSleeping;
		statusWord[STAT_MEMRDY_BIT]  = memProgAllowed;
		statusWord[STAT_UROWRDY_BIT] = userRowAllowed;
		statusWord[STAT_LOCK_BIT]    = deviceLocked;
	end

	// read data mux
	assign rdData_next = !regRdEn ? rdData_reg :
		(regAddr == SYS_CTRL_ADDR) ? {6'h00, 1'b0, clock_request_reg} :
		(regAddr == SYS_STATUS_ADDR) ? statusWord :
		(regAddr == CRC_STATUS_ADDR) ? {5'h00, crcCode} :
		8'h00;

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clock_request_reg  <= SYS_CTRL_RESET[CTRL_CLOCK_BIT];
			rstReq_reg  <= 1'b0;
			rstAct_reg  <= 1'b0;
			row_reg     <= DPSC_ROW_IDLE;
			start_reg   <= 1'b0;
			useData_reg <= 1'b0;
			rdData_reg  <= 8'h00;
		end else begin
			clock_request_reg  <= clock_request_next;
			rstReq_reg  <= rstReq_next;
			rstAct_reg  <= rstAct_next;
			row_reg     <= row_next;
			start_reg   <= finishHit;
			useData_reg <= finishHit && userRowDataInRam;
			rdData_reg  <= rdData_next;
		end
	end

	assign regRdData        = rdData_reg;
	assign sysClockRequest  = clock_request_reg;
	assign sysResetRequest  = rstReq_reg;
	assign userRowProgStart = start_reg;
	assign userRowUseData   = useData_reg;
endmodule : dpsc_top

// ===== dpsc_props.sv
// ****************************************
// register side checker
// ****************************************
module dpsc_props (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst,
	// register access
	input wire logic       regWrEn,
	input wire logic       regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	// port state
	input wire logic       portEnable,
	input wire logic       progEntry,
	input wire logic       userRowKeyOk,
	input wire logic       userRowDataInRam,
	// system state
	input wire logic       sysInReset,
	input wire logic       sysSleeping,
	input wire logic       memProgAllowed,
	input wire logic       userRowAllowed,
	input wire logic       deviceLocked,
	input wire logic       crcEnabled,
	input wire logic       crcDone,
	input wire logic       crcPass,
	// system requests
	input wire logic       sysClockRequest,
	input wire logic       sysResetRequest,
	input wire logic       userRowProgStart,
	input wire logic       userRowUseData
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// decoded accesses
	wire wCtl  = regWrEn && regAddr == 8'h0A;
	wire wRst  = regWrEn && regAddr == 8'h08;
	wire rSt   = regRdEn && regAddr == 8'h0B;
	wire rCrc  = regRdEn && regAddr == 8'h0C;
	wire cause = sysInReset || sysResetRequest;
	wire wNorm = portEnable && !progEntry && wCtl;
	// clock request
	chk_clk_off: assert property (!portEnable |=> !sysClockRequest)
		else $error("clk kept");
	chk_clk_entry: assert property (portEnable && progEntry |=> sysClockRequest)
		else $error("no entry clk");
	chk_clk_set: assert property (wNorm && regWrData[0] |=> sysClockRequest)
		else $error("no clk");
	chk_clk_clr: assert property (wNorm && !regWrData[0] |=> !sysClockRequest)
		else $error("clk");
	// user row finish
	chk_row_key: assert property (wCtl && !userRowKeyOk |=> !userRowProgStart)
		else $error("key");
	chk_row_go: assert property (wCtl && regWrData[1] && userRowKeyOk |=>
		userRowProgStart && userRowUseData == $past(userRowDataInRam))
		else $error("row start");
	// reset request
	chk_rst_on: assert property (wRst && regWrData == 8'h59 |=> sysResetRequest)
		else $error("rst");
	chk_rst_off: assert property (wRst && regWrData == 8'h00 |=> !sysResetRequest)
		else $error("run");
	// read data
	chk_crc_code: assert property (rCrc |=> regRdData == (!$past(crcEnabled) ? 8'h00 :
		!$past(crcDone) ? 8'h01 : $past(crcPass) ? 8'h02 : 8'h04)) else $error("crc code");
	chk_stat_bits: assert property (rSt |=> regRdData[7:6] == 2'h0 &&
		regRdData[4:0] == {$past(sysSleeping), $past(memProgAllowed), $past(userRowAllowed),
		1'h0, $past(deviceLocked)}) else $error("status bits");
	chk_rst_seen: assert property (cause ##1 rSt |=> regRdData[5])
		else $error("rst hidden");
	chk_rst_clear: assert property (rSt && !cause ##1 !cause ##1 rSt && !cause |=>
		!regRdData[5]) else $error("rst kept");
	// main scenarios
	cover property (wCtl && regWrData[1] && userRowKeyOk && userRowDataInRam);
	cover property (wRst && regWrData == 8'h59);
	cover property (rCrc && crcEnabled && crcDone && !crcPass);
	cover property (portEnable && progEntry);
endmodule // dpsc_props
bind dpsc_top dpsc_props chk (.*);

// ===== dpsc_dbg_model.sv
// ****
// debugger side of the register access
// ****
module dpsc_dbg_model (
	// clock
	input wire logic       clk_sys,
	// register access towards the block
	output logic           regWrEn,
	output logic           regRdEn,
	output logic     [7:0] regAddr,
	output logic     [7:0] regWrData,
	// answer from the block
	input wire logic [7:0] regRdData
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {regWrEn, regRdEn, regAddr, regWrData} = '0;
	// one byte write, data scrambled after release
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys);
		{regWrEn, regAddr, regWrData} <= {1'h1, a, d};
		@(posedge clk_sys);
		{regWrEn, regWrData} <= {1'h0, ~d};
	endtask
	// one byte read, data taken after the answer edge
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk_sys);
		{regRdEn, regAddr} <= {1'h1, a};
		@(posedge clk_sys);
		regRdEn <= 1'h0;
		#1 q = regRdData;
	endtask
endmodule // dpsc_dbg_model

// ===== tb_debug_port_system_ctrl_status.sv
module tb_debug_port_system_ctrl_status;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'h0, rst = 1'h1, portEnable = 1'h1, progEntry = 1'h0, userRowKeyOk = 1'h0;
	logic userRowDataInRam = 1'h0, sysInReset = 1'h0, sysSleeping = 1'h0, memProgAllowed = 1'h0;
	logic userRowAllowed = 1'h0, deviceLocked = 1'h1, crcEnabled = 1'h0, crcDone = 1'h0;
	logic crcPass = 1'h0, regWrEn, regRdEn, sysClockRequest, sysResetRequest;
	logic userRowProgStart, userRowUseData;
	logic [7:0] regAddr, regWrData, regRdData, q;
	int n_fail = 0, checks = 0;
	always #50 clk_sys = ~clk_sys;
	dpsc_top uut (.*);
	dpsc_dbg_model dbg (.*);
	// compare and report
	task automatic chk(input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %0t saw %h want %h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, e);
		dbg.rd(a, q);
		chk(q, e);
	endtask
	task automatic final_report;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// clock request paths
	task automatic t_clk;
		rc(8'h0B, 8'h01);
		dbg.wr(8'h0A, 8'hFF);
		#1 chk({userRowProgStart, sysClockRequest}, 8'h01);
		rc(8'h0A, 8'h01);
		dbg.wr(8'h0A, 8'h00);
		#1 chk(sysClockRequest, 8'h00);
		@(posedge clk_sys) progEntry <= 1'h1;
		@(posedge clk_sys) progEntry <= 1'h0;
		#1 chk(sysClockRequest, 8'h01);
		@(posedge clk_sys) portEnable <= 1'h0;
		@(posedge clk_sys) portEnable <= 1'h1;
		#1 chk(sysClockRequest, 8'h00);
	endtask
	// user row finish with and without data
	task automatic t_row;
		@(posedge clk_sys) userRowKeyOk <= 1'h1;
		dbg.wr(8'h0A, 8'h02);
		#1 chk({userRowProgStart, userRowUseData}, 8'h02);
		@(posedge clk_sys) userRowDataInRam <= 1'h1;
		dbg.wr(8'h0A, 8'h02);
		#1 chk({userRowProgStart, userRowUseData}, 8'h03);
	endtask
	// reset request and sticky reset flag
	task automatic t_rst;
		dbg.wr(8'h08, 8'h59);
		#1 chk(sysResetRequest, 8'h01);
		rc(8'h0B, 8'h21);
		dbg.wr(8'h08, 8'h33);
		#1 chk(sysResetRequest, 8'h01);
		dbg.wr(8'h08, 8'h00);
		#1 chk(sysResetRequest, 8'h00);
		rc(8'h0B, 8'h21);
		rc(8'h0B, 8'h01);
		@(posedge clk_sys) sysInReset <= 1'h1;
		@(posedge clk_sys) sysInReset <= 1'h0;
		rc(8'h0B, 8'h21);
		rc(8'h0B, 8'h01);
		@(posedge clk_sys) {sysSleeping, memProgAllowed, userRowAllowed, deviceLocked} <= 4'hE;
		rc(8'h0B, 8'h1C);
	endtask
	// every checksum code, then read-only and unmapped places
	task automatic t_crc;
		logic [2:0] cond [4] = '{3'h0, 3'h4, 3'h7, 3'h6};
		logic [7:0] code [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys) {crcEnabled, crcDone, crcPass} <= cond[i];
			rc(8'h0C, code[i]);
		end
		dbg.wr(8'h0C, 8'hFF);
		rc(8'h0C, 8'h04);
		rc(8'h30, 8'h00);
	endtask
	// main sequence and hang guard
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'h0;
		t_clk();
		t_row();
		t_rst();
		t_crc();
		final_report();
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		final_report();
	end
endmodule // tb_debug_port_system_ctrl_status
